// File: rtl/port_a_pin_function_select.sv
// Port A pin function select: direction and function registers, pad muxing.
// Assumes an AHB-Lite master with single word transfers and synchronous pad inputs.
`timescale 1ns/10ps

// Contract
// - Direction bit 1 makes its pin an output, 0 an input.
// - Low direction register acts only for port I/O or serial clock pins.
// - High direction register acts only while pins 23..16 are port I/O.
// - Both direction registers are 16-bit read/write, one bit per pin.
// - High direction bits 15..8 read 0; software writes 0 there.
// - Smaller variant: high direction bits 7..0 are disabled, no pin effect.
// - Reset clears both direction registers, so all pins start as inputs.
// - Three 16-bit read/write function registers select each pin function.
// - Smaller variant: listed reserved function bits read 0; software writes 0.
// - First low function bit 14 puts system clock output on pin 15.
// - First low function bit 12 puts read strobe output on pin 14.
// - First low function bit 10 puts upper write strobe on pin 13.
module port_a_pin_function_select
   import pfc_port_a_pkg::*;
#(
   parameter bit small_variant = 1'b0
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Dedicated alternate sources
   input wire logic system_clock_output,
   input wire logic read_strobe_output,
   input wire logic upper_write_strobe_output,
   // Other peripheral functions, one bit per pin
   input wire logic [23:0] alt_data,
   input wire logic [23:0] alt_oe,
   // Port data register output
   input wire logic [23:0] port_data,
   // Pads
   input wire logic [23:0] pin_in,
   output logic [23:0] pin_out,
   output logic [23:0] pin_oe_n,
   // Sampled pad levels and pin modes
   output logic [23:0] pin_level,
   output logic [23:0] port_mode
);

   // Writable masks for this variant
   localparam logic [15:0] mask_direction_high =
      small_variant ? mask_direction_high_small : mask_direction_high_full;
   localparam logic [15:0] mask_function_high =
      small_variant ? mask_function_high_small : mask_function_full;
   localparam logic [15:0] mask_function_low_first =
      small_variant ? mask_function_low_first_small : mask_function_full;
   localparam logic [15:0] mask_function_low_second =
      small_variant ? mask_function_low_second_small : mask_function_full;

   // Registers
   logic [15:0] port_a_direction_low;
   logic [15:0] port_a_direction_high;
   logic [15:0] port_a_function_high;
   logic [15:0] port_a_function_low_first;
   logic [15:0] port_a_function_low_second;

   // Bus state
   logic write_pending;
   logic [7:0] write_offset;
   logic access_valid;
   logic [31:0] next_hrdata;

   // Pin decode
   logic [23:0] direction_bits;
   logic [23:0] direction_governs;
   logic [23:0] select_port;
   logic [23:0] cell_alt_data;
   logic [23:0] cell_alt_oe;
   logic [1:0] field [24];

   // Bus answer
   // Registers answer with no wait state and always OKAY
   assign hreadyout = 1'b1;
   assign hresp = hresp_okay;

   assign access_valid = hsel && hready && (htrans == htrans_nonseq || htrans == htrans_seq) && hsize == hsize_word;

   // Address phase of a write
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         write_pending <= 1'b0;
         write_offset <= 8'h00;
      end
      else if (hready)
      begin
         write_pending <= access_valid && hwrite && haddr[31:8] == 24'h000000;
         write_offset <= haddr[7:0];
      end
   end

   // Read data, prepared in the address phase
   always_comb
   begin
      next_hrdata = 32'h00000000;
      if (haddr[31:8] == 24'h000000)
      begin
         case (haddr[7:0])
            off_direction_low:
               next_hrdata = {16'h0000, port_a_direction_low};
            off_direction_high:
               next_hrdata = {16'h0000, port_a_direction_high};
            off_function_high:
               next_hrdata = {16'h0000, port_a_function_high};
            off_function_low_first:
               next_hrdata = {16'h0000, port_a_function_low_first};
            off_function_low_second:
               next_hrdata = {16'h0000, port_a_function_low_second};
            off_drive_status:
               next_hrdata = {8'h00, ~pin_oe_n};
            default:
               next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         hrdata <= 32'h00000000;
      end
      else if (access_valid && !hwrite)
      begin
         hrdata <= next_hrdata;
      end
   end

   // Direction registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         port_a_direction_low <= reset_direction;
         port_a_direction_high <= reset_direction;
      end
      else if (write_pending)
      begin
         if (write_offset == off_direction_low)
         begin
            port_a_direction_low <= hwdata[15:0] & mask_direction_low;
         end
         if (write_offset == off_direction_high)
         begin
            // Reserved and disabled bits never store
            port_a_direction_high <= hwdata[15:0] & mask_direction_high;
         end
      end
   end

   // Function registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         port_a_function_high <= reset_function;
         port_a_function_low_first <= reset_function;
         port_a_function_low_second <= reset_function;
      end
      else if (write_pending)
      begin
         if (write_offset == off_function_high)
         begin
            port_a_function_high <= hwdata[15:0] & mask_function_high;
         end
         if (write_offset == off_function_low_first)
         begin
            port_a_function_low_first <= hwdata[15:0] & mask_function_low_first;
         end
         if (write_offset == off_function_low_second)
         begin
            port_a_function_low_second <= hwdata[15:0] & mask_function_low_second;
         end
      end
   end

   // Pad levels for the port data path and peripherals
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_level <= 24'h000000;
      end
      else
      begin
         pin_level <= pin_in;
      end
   end

   assign direction_bits = {port_a_direction_high[7:0], port_a_direction_low};

   // Per-pin decode and pad cell
   genvar i;
   generate
      for (i = 0; i < pins_total; i++)
      begin : g_pin
         localparam int unsigned lo = field_width * (i % pins_per_reg);

         if (i >= pins_low)
         begin : g_high
            assign field[i] = port_a_function_high[lo +: field_width];
         end
         else if (i >= pins_per_reg)
         begin : g_first
            assign field[i] = port_a_function_low_first[lo +: field_width];
         end
         else
         begin : g_second
            assign field[i] = port_a_function_low_second[lo +: field_width];
         end

         if (i == pin_system_clock || i == pin_read_strobe || i == pin_upper_write)
         begin : g_mode_one
            // Single select bit; the bit above it plays no part
            assign port_mode[i] = !field[i][0];
         end
         else
         begin : g_mode_two
            assign port_mode[i] = (field[i] == field_port);
         end

         if (i >= pins_low)
         begin : g_gov_high
            // Pins absent in the smaller variant stay inputs
            assign direction_governs[i] = port_mode[i] || small_variant;
         end
         else if (i == pin_serial0_clock || i == pin_serial1_clock)
         begin : g_gov_serial
            assign direction_governs[i] = port_mode[i] || field[i] == field_serial_clock;
         end
         else
         begin : g_gov_low
            assign direction_governs[i] = port_mode[i];
         end

         assign select_port[i] = port_mode[i];

         if (i == pin_system_clock)
         begin : g_sysclk
            assign cell_alt_data[i] = system_clock_output;
            assign cell_alt_oe[i] = port_a_function_low_first[bit_pin15_function_select];
         end
         else if (i == pin_read_strobe)
         begin : g_rd
            assign cell_alt_data[i] = read_strobe_output;
            assign cell_alt_oe[i] = port_a_function_low_first[bit_pin14_function_select];
         end
         else if (i == pin_upper_write)
         begin : g_wrh
            assign cell_alt_data[i] = upper_write_strobe_output;
            assign cell_alt_oe[i] = port_a_function_low_first[bit_pin13_function_select];
         end
         else if (i >= pins_low && small_variant)
         begin : g_absent
            assign cell_alt_data[i] = 1'b0;
            assign cell_alt_oe[i] = 1'b0;
         end
         else
         begin : g_other
            assign cell_alt_data[i] = alt_data[i];
            assign cell_alt_oe[i] = alt_oe[i];
         end

         pin_drive_cell u_cell
         (
            .clock(clock),
            .nrst(nrst),
            .direction_governs(direction_governs[i]),
            .direction_bit(direction_bits[i]),
            .select_port(select_port[i]),
            .port_data(port_data[i]),
            .alt_data(cell_alt_data[i]),
            .alt_oe(cell_alt_oe[i]),
            .pin_out(pin_out[i]),
            .pin_oe_n(pin_oe_n[i])
         );
      end
   endgenerate

endmodule

// File: inc/pfc_port_a_pkg.sv
// Constants for the port A slice of the pin function controller.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package pfc_port_a_pkg;

   // Pin counts
   localparam int unsigned pins_low = 16;
   localparam int unsigned pins_high = 8;
   localparam int unsigned pins_total = 24;
   localparam int unsigned reg_width = 16;

   // Register byte offsets within the block
   localparam logic [7:0] off_direction_low = 8'h00;
   localparam logic [7:0] off_direction_high = 8'h04;
   localparam logic [7:0] off_function_high = 8'h08;
   localparam logic [7:0] off_function_low_first = 8'h0c;
   localparam logic [7:0] off_function_low_second = 8'h10;
   localparam logic [7:0] off_drive_status = 8'h14;

   // Values after reset
   localparam logic [15:0] reset_direction = 16'h0000;
   localparam logic [15:0] reset_function = 16'h0000;

   // Writable bits, full variant
   localparam logic [15:0] mask_direction_low = 16'hffff;
   localparam logic [15:0] mask_direction_high_full = 16'h00ff;
   localparam logic [15:0] mask_function_full = 16'hffff;

   // Writable bits, smaller variant
   localparam logic [15:0] mask_direction_high_small = 16'h0000;
   localparam logic [15:0] mask_function_high_small = 16'h55f7;
   localparam logic [15:0] mask_function_low_first_small = 16'h555f;
   localparam logic [15:0] mask_function_low_second_small = 16'hfd75;

   // Function fields: pin i uses bits 2*(i%8)+1 : 2*(i%8)
   localparam int unsigned field_width = 2;
   localparam int unsigned pins_per_reg = 8;
   localparam logic [1:0] field_port = 2'h0;
   localparam logic [1:0] field_serial_clock = 2'h1;

   // Pins with a dedicated alternate source
   localparam int unsigned pin_system_clock = 15;
   localparam int unsigned pin_read_strobe = 14;
   localparam int unsigned pin_upper_write = 13;
   localparam int unsigned bit_pin15_function_select = 14;
   localparam int unsigned bit_pin14_function_select = 12;
   localparam int unsigned bit_pin13_function_select = 10;

   // Serial clock pins of the two serial channels
   localparam int unsigned pin_serial0_clock = 2;
   localparam int unsigned pin_serial1_clock = 5;

   // Bus encodings
   localparam logic [2:0] hsize_word = 3'h2;
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [1:0] htrans_seq = 2'h3;
   localparam logic hresp_okay = 1'b0;

endpackage

// File: rtl/pin_drive_cell.sv
// One port A pin: chooses data and drive for the pad.
// Assumes its controls come from registers in the same clock domain.
`timescale 1ns/10ps

module pin_drive_cell
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Controls
   input wire logic direction_governs,
   input wire logic direction_bit,
   input wire logic select_port,
   // Data sources
   input wire logic port_data,
   input wire logic alt_data,
   input wire logic alt_oe,
   // Pad
   output logic pin_out,
   output logic pin_oe_n
);

   logic next_drive;
   logic next_data;

   always_comb
   begin
      // Direction bit acts only where the pin function lets it
      next_drive = direction_governs ? direction_bit : alt_oe;
      next_data = select_port ? port_data : alt_data;
   end

   // Registered pad drive keeps the pad free of decode glitches
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end
      else
      begin
         pin_out <= next_data;
         pin_oe_n <= ~next_drive;
      end
   end

endmodule

// File: testbench/port_a_pin_function_select_asserts.sv
// Checker for the port A pin function select block.
// Sees only top-level ports; bound in below the module.
`timescale 1ns/10ps
module port_a_pin_function_select_asserts
   import pfc_port_a_pkg::*;
#(
   parameter bit small_variant = 1'b0
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Sources
   input wire logic system_clock_output,
   input wire logic read_strobe_output,
   input wire logic upper_write_strobe_output,
   input wire logic [23:0] alt_data,
   input wire logic [23:0] alt_oe,
   input wire logic [23:0] port_data,
   // Pads
   input wire logic [23:0] pin_out,
   input wire logic [23:0] pin_oe_n,
   input wire logic [23:0] port_mode
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   // Read of the high direction register taken
   sequence s_rd_high;
      hsel && hready && htrans[1] && !hwrite && hsize == hsize_word && haddr == {24'h0, off_direction_high};
   endsequence
   // Read of one of the five registers taken
   sequence s_rd_reg;
      hsel && hready && htrans[1] && !hwrite && hsize == hsize_word && haddr < {24'h0, off_drive_status};
   endsequence
   // Pin 16 outside port mode, one cycle back, where the pin exists
   sequence s_pin16_alt;
      !small_variant && $past(nrst) && !$past(port_mode[16]);
   endsequence

   property p_reset_inputs;
      $rose(nrst) |-> pin_oe_n == 24'hffffff;
   endproperty
   property p_dir_high_reserved;
      s_rd_high |=> hrdata[15:8] == 8'h00;
   endproperty
   property p_upper_zero;
      s_rd_reg |=> hrdata[31:16] == 16'h0000;
   endproperty
   property p_absent_high;
      small_variant |-> pin_oe_n[23:16] == 8'hff;
   endproperty
   property p_pin15;
      $past(nrst) && !$past(port_mode[15]) |-> pin_out[15] == $past(system_clock_output) && !pin_oe_n[15];
   endproperty
   property p_pin14;
      $past(nrst) && !$past(port_mode[14]) |-> pin_out[14] == $past(read_strobe_output) && !pin_oe_n[14];
   endproperty
   property p_pin13;
      $past(nrst) && !$past(port_mode[13]) |-> pin_out[13] == $past(upper_write_strobe_output) && !pin_oe_n[13];
   endproperty
   property p_pin16_alt;
      s_pin16_alt |-> pin_oe_n[16] == !$past(alt_oe[16]) && pin_out[16] == $past(alt_data[16]);
   endproperty
   property p_port_data;
      $past(nrst) && $past(port_mode[0]) |-> pin_out[0] == $past(port_data[0]);
   endproperty

   a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset");
   a_dir_high_reserved: assert property (p_dir_high_reserved) else $error("reserved bits nonzero");
   a_upper_zero: assert property (p_upper_zero) else $error("read data upper half nonzero");
   a_pin15: assert property (p_pin15) else $error("pin 15 source wrong");
   a_pin14: assert property (p_pin14) else $error("pin 14 source wrong");
   a_pin13: assert property (p_pin13) else $error("pin 13 source wrong");
   a_pin16_alt: assert property (p_pin16_alt) else $error("pin 16 follows direction");
   a_port_data: assert property (p_port_data) else $error("pin 0 data late or wrong");
   a_absent_high: assert property (p_absent_high) else $error("absent high pin driven");
endmodule

bind port_a_pin_function_select port_a_pin_function_select_asserts #(.small_variant(small_variant)) u_chk (.clock,
   .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata, .system_clock_output, .read_strobe_output,
   .upper_write_strobe_output,
   .alt_data, .alt_oe, .port_data, .pin_out, .pin_oe_n, .port_mode);

// File: testbench/port_a_pin_function_select_bench.sv
// Self-checking bench for the port A pin function select block.
// Acts as the only AHB-Lite master; hready loops back from hreadyout.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t: %h not %h", $time, g, e); end end
module port_a_pin_function_select_bench
   import pfc_port_a_pkg::*;
;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = hsize_word;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] src = 3'h0;
   logic [23:0] alt_data = 24'h0;
   logic [23:0] alt_oe = 24'h0;
   logic [23:0] port_data = 24'h0;
   logic [23:0] pin_in = 24'h0;
   wire logic hready;
   wire logic [31:0] hrdata;
   wire logic [23:0] pin_out;
   wire logic [23:0] pin_oe_n;
   wire logic [23:0] port_mode;
   wire logic hresp;
   wire logic [23:0] pin_level;
   wire logic [31:0] hrdata_small;
   wire logic [23:0] pin_oe_n_small;
   logic [15:0] rd;
   logic [15:0] rd_small;
   int fails = 0;
   int tests_run = 0;

   always #5 clock = ~clock;

   port_a_pin_function_select DUT (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout(hready), .hresp(hresp), .hrdata, .system_clock_output(src[2]), .read_strobe_output(src[1]),
      .upper_write_strobe_output(src[0]), .alt_data, .alt_oe, .port_data, .pin_in, .pin_out, .pin_oe_n,
      .pin_level(pin_level), .port_mode);

   // Smaller variant on the same bus
   port_a_pin_function_select #(.small_variant(1'b1)) DUT_small (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout(), .hresp(), .hrdata(hrdata_small), .system_clock_output(src[2]),
      .read_strobe_output(src[1]), .upper_write_strobe_output(src[0]), .alt_data, .alt_oe, .port_data, .pin_in,
      .pin_out(), .pin_oe_n(pin_oe_n_small), .pin_level(), .port_mode());

   // One single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= htrans_nonseq;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata[15:0];
      rd_small = hrdata_small[15:0];
   endtask

   // Smaller variant keeps only its writable bits
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] m;
      bus(1'b0, a, 16'h0);
      case (a)
         off_direction_high: m = mask_direction_high_small;
         off_function_high: m = mask_function_high_small;
         off_function_low_first: m = mask_function_low_first_small;
         off_function_low_second: m = mask_function_low_second_small;
         default: m = 16'hffff;
      endcase
      `CHK(rd, e)
      `CHK(rd_small, e & m)
   endtask

   task automatic settle;
      repeat (2) @(negedge clock);
   endtask

   task automatic results;
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (4000) @(posedge clock);
      fails++;
      results;
   end

   initial
   begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++)
         chk_rd(8'(4 * i), reset_direction);
      `CHK(pin_oe_n, 24'hffffff)
      bus(1'b1, off_direction_low, 16'ha5c3);
      chk_rd(off_direction_low, 16'ha5c3);
      bus(1'b1, off_direction_high, 16'hffff);
      chk_rd(off_direction_high, 16'h00ff);
      for (int i = 2; i < 5; i++)
      begin
         bus(1'b1, 8'(4 * i), 16'hffff);
         chk_rd(8'(4 * i), 16'hffff);
         bus(1'b1, 8'(4 * i), 16'h0000);
      end
      // Unmapped place ignores writes
      bus(1'b1, 8'h18, 16'hffff);
      chk_rd(8'h18, 16'h0000);
      // Direction in port mode, one cycle after the write
      port_data <= 24'h5a5a5a;
      pin_in <= 24'hc3a5e1;
      bus(1'b1, off_direction_low, 16'h00ff);
      bus(1'b1, off_direction_high, 16'h000f);
      @(negedge clock);
      `CHK(pin_oe_n[23:16], 8'h00)
      @(negedge clock);
      `CHK(pin_oe_n, 24'hf0ff00)
      `CHK(pin_out, 24'h5a5a5a)
      `CHK(pin_level, 24'hc3a5e1)
      `CHK(pin_oe_n_small[23:16], 8'hff)
      chk_rd(off_drive_status, 16'h00ff);
      // Serial clock pin 2 stays governed, pin 1 does not
      bus(1'b1, off_function_low_second, 16'h0014);
      settle;
      `CHK(pin_oe_n[2:1], 2'b01)
      `CHK(port_mode[2:1], 2'b00)
      bus(1'b1, off_function_high, 16'h0001);
      settle;
      `CHK(pin_oe_n[16], 1'b1)
      @(posedge clock);
      alt_oe <= 24'h010000;
      alt_data <= 24'h010000;
      // Dedicated sources on pins 15..13, direction bits clear
      bus(1'b1, off_function_low_first, 16'h5400);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clock);
         src <= v[0] ? 3'h2 : 3'h5;
         settle;
         `CHK(pin_out[15], src[2])
         `CHK(pin_out[14], src[1])
         `CHK(pin_out[13], src[0])
         `CHK(pin_oe_n[15:13], 3'h0)
      end
      // Select bit clear means port I/O whatever the bit above holds
      bus(1'b1, off_function_low_first, 16'h8000);
      settle;
      `CHK(port_mode[15], 1'b1)
      // Reset in mid-run
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      `CHK(pin_oe_n, 24'hffffff)
      nrst <= 1'b1;
      chk_rd(off_direction_low, reset_direction);
      chk_rd(off_direction_high, reset_direction);
      `CHK(hresp, hresp_okay)
      results;
   end
endmodule
